// [core/flash_cmd_sequencer.sv]
/*
 * APB-controlled host that drives a parallel flash through its pins.
 * Assumes pins synchronous to pclk and a flash that answers within the
 * timing constants of the package.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps

module flash_cmd_sequencer
    import flash_host_pkg::*;
#(
    parameter int BANK_W = 2
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic      [FLASH_AW-1:0] flash_addr,
    output logic      [15:0]         flash_dq_out,
    output logic                     flash_dq_oe,
    input  wire logic [15:0]         flash_dq_in,
    output logic                     flash_ce_n,
    output logic                     flash_we_n,
    output logic                     flash_oe_n,
    output logic                     flash_reset_n,
    output logic                     width_byte_n,
    output logic                     protect_accel_pin,
    input  wire logic                ready_busy_n
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_SETUP = 7'h02,
        S_PULSE = 7'h04,
        S_HOLD  = 7'h08,
        S_READ  = 7'h10,
        S_BUSY  = 7'h20,
        S_HWRST = 7'h40
    } state_t;

    state_t              state_ff, nxt_state;
    op_t                 op_ff, nxt_op;
    logic [2:0]          idx_ff, nxt_idx;
    logic [7:0]          cnt_ff, nxt_cnt;
    logic [FLASH_AW-1:0] uaddr_ff, nxt_uaddr, addr_ff, nxt_addr;
    logic [15:0]         wdata_ff, nxt_wdata, dq_ff, nxt_dq, rdata_ff, nxt_rdata;
    logic dq_oe_ff, nxt_dq_oe, ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n;
    logic oe_n_ff, nxt_oe_n, rst_n_ff, nxt_rst_n, byte_ff, nxt_byte;
    logic accel_ff, nxt_accel, query_ff, nxt_query, secured_ff, nxt_secured;
    logic bypass_ff, nxt_bypass, err_ff, nxt_err, done_ff, nxt_done;
    logic byte_n_ff, nxt_byte_n;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic        access, start, refuse;
    op_t         start_op;
    step_t       step;

    // ------------------------------------------------------------------
    // Sequence table
    // ------------------------------------------------------------------
    function automatic step_t seq_step(input op_t op, input logic [2:0] i,
                                       input logic bm,
                                       input logic [FLASH_AW-1:0] ua,
                                       input logic [15:0] ud);
        logic [FLASH_AW-1:0] a1, a2, ba;
        logic                second;
        step_t               s;
        a1 = FLASH_AW'(bm ? UNL_A1_BYTE : UNL_A1_WORD);
        a2 = FLASH_AW'(bm ? UNL_A2_BYTE : UNL_A2_WORD);
        ba = {ua[FLASH_AW-1 -: BANK_W], {(FLASH_AW-BANK_W){1'b0}}};
        second = (i == 3'h1) || (i == 3'h4);
        s.addr = second ? a2 : a1;
        s.data = {8'h00, second ? CMD_UNLOCK2 : CMD_UNLOCK1};
        s.last = 1'b0;
        case (op)
            OP_RESET: begin
                s.data = {8'h00, CMD_RESET};
                s.last = 1'b1;
            end
            OP_QUERY: if (i == 3'h2) begin
                s.addr = ba | a1;
                s.data = {8'h00, CMD_QUERY};
                s.last = 1'b1;
            end
            OP_SEC_ENTER: if (i == 3'h2) begin
                s.data = {8'h00, CMD_SEC_IN};
                s.last = 1'b1;
            end
            OP_SEC_EXIT: if (i == 3'h2) begin
                s.data = {8'h00, CMD_SEC_OUT};
            end else if (i == 3'h3) begin
                s.data = {8'h00, CMD_EXIT2};
                s.last = 1'b1;
            end
            OP_PROGRAM: if (i == 3'h2) begin
                s.data = {8'h00, CMD_PROG};
            end else if (i == 3'h3) begin
                s.addr = ua;
                s.data = ud;
                s.last = 1'b1;
            end
            OP_BYP_ENTER: if (i == 3'h2) begin
                s.data = {8'h00, CMD_BYPASS};
                s.last = 1'b1;
            end
            OP_BYP_PROG: if (i == 3'h0) begin
                s.data = {8'h00, CMD_PROG};
            end else begin
                s.addr = ua;
                s.data = ud;
                s.last = 1'b1;
            end
            OP_BYP_RESET: if (i == 3'h0) begin
                s.data = {8'h00, CMD_BYP_OUT};
            end else begin
                s.data = {8'h00, CMD_EXIT2};
                s.last = 1'b1;
            end
            OP_CHIP_ER: if (i == 3'h2) begin
                s.data = {8'h00, CMD_ER_SETUP};
            end else if (i == 3'h5) begin
                s.data = {8'h00, CMD_CHIP_ER};
                s.last = 1'b1;
            end
            default: s.last = 1'b1;
        endcase
        return s;
    endfunction : seq_step

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_comb begin
        access      = psel && penable && pready_ff;
        start       = access && pwrite && (paddr == OFF_CTRL);
        start_op    = op_t'(pwdata[3:0]);
        nxt_pready  = psel && penable && !pready_ff;
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (nxt_pready) begin
            if (paddr == OFF_CTRL) begin
                nxt_prdata = {28'h000_0000, op_ff};
            end else if (paddr == OFF_ADDR) begin
                nxt_prdata = 32'(uaddr_ff);
            end else if (paddr == OFF_WDATA) begin
                nxt_prdata = {16'h0000, wdata_ff};
            end else if (paddr == OFF_STATUS) begin
                nxt_prdata[ST_BUSY]    = (state_ff != S_IDLE);
                nxt_prdata[ST_ERR]     = err_ff;
                nxt_prdata[ST_QUERY]   = query_ff;
                nxt_prdata[ST_SECURED] = secured_ff;
                nxt_prdata[ST_BYPASS]  = bypass_ff || accel_ff;
                nxt_prdata[ST_RB]      = ready_busy_n;
                nxt_prdata[ST_DONE]    = done_ff;
            end else if (paddr == OFF_RDATA) begin
                nxt_prdata = {16'h0000, rdata_ff};
            end else if (paddr == OFF_CONFIG) begin
                nxt_prdata[CFG_BYTE]  = byte_ff;
                nxt_prdata[CFG_ACCEL] = accel_ff;
            end else begin
                nxt_pslverr = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    always_comb begin
        step = seq_step(op_ff, idx_ff, byte_ff, uaddr_ff, wdata_ff);
        refuse = (state_ff != S_IDLE)
               || (start_op > OP_HW_RESET)
               || (!ready_busy_n && start_op != OP_READ
                   && start_op != OP_HW_RESET)
               || (query_ff && start_op != OP_RESET
                   && start_op != OP_READ
                   && start_op != OP_HW_RESET)
               || ((bypass_ff || accel_ff) && start_op != OP_BYP_PROG
                   && start_op != OP_BYP_RESET && start_op != OP_READ
                   && start_op != OP_HW_RESET)
               || (secured_ff && (start_op == OP_BYP_ENTER
                   || start_op == OP_BYP_PROG))
               || (start_op == OP_BYP_PROG && !bypass_ff && !accel_ff);
        nxt_state = state_ff;   nxt_op    = op_ff;      nxt_idx = idx_ff;
        nxt_cnt   = cnt_ff;     nxt_addr  = addr_ff;    nxt_dq  = dq_ff;
        nxt_dq_oe = dq_oe_ff;   nxt_ce_n  = 1'b1;       nxt_we_n = 1'b1;
        nxt_oe_n  = 1'b1;       nxt_rst_n = 1'b1;       nxt_rdata = rdata_ff;
        nxt_uaddr = uaddr_ff;   nxt_wdata = wdata_ff;   nxt_byte = byte_ff;
        nxt_accel = accel_ff && !secured_ff;
        nxt_query = query_ff;   nxt_secured = secured_ff;
        nxt_bypass = bypass_ff;
        nxt_err  = err_ff;
        nxt_done = done_ff;
        if (access && pwrite) begin
            if (paddr == OFF_ADDR) begin
                nxt_uaddr = pwdata[FLASH_AW-1:0];
            end else if (paddr == OFF_WDATA) begin
                nxt_wdata = pwdata[15:0];
            end else if (paddr == OFF_STATUS) begin
                nxt_err  = err_ff && !pwdata[ST_ERR];
                nxt_done = done_ff && !pwdata[ST_DONE];
            end else if (paddr == OFF_CONFIG) begin
                nxt_byte  = pwdata[CFG_BYTE];
                nxt_accel = pwdata[CFG_ACCEL] && !secured_ff;
            end
        end
        case (state_ff)
            S_IDLE: if (start) begin
                if (refuse) begin
                    nxt_err = 1'b1;
                end else begin
                    nxt_op  = start_op;
                    nxt_idx = 3'h0;
                    if (start_op == OP_READ) begin
                        nxt_state = S_READ;
                        nxt_addr  = uaddr_ff;
                        nxt_dq_oe = 1'b0;
                        nxt_cnt   = ACC_CYC;
                    end else if (start_op == OP_HW_RESET) begin
                        nxt_state = S_HWRST;
                        nxt_cnt   = RP_CYC;
                    end else begin
                        nxt_state = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                nxt_addr  = step.addr;
                nxt_dq    = step.data;
                nxt_dq_oe = 1'b1;
                nxt_cnt   = WP_CYC;
                nxt_state = S_PULSE;
            end
            S_PULSE: begin
                nxt_ce_n = 1'b0;
                nxt_we_n = 1'b0;
                nxt_cnt  = cnt_ff - 8'h01;
                if (cnt_ff == 8'h00) begin
                    nxt_ce_n  = 1'b1;
                    nxt_we_n  = 1'b1;
                    nxt_state = S_HOLD;
                end
            end
            S_HOLD: begin
                nxt_dq_oe = 1'b0;
                if (!step.last) begin
                    nxt_idx   = idx_ff + 3'h1;
                    nxt_state = S_SETUP;
                end else begin
                    case (op_ff)
                        OP_QUERY:     nxt_query = 1'b1;
                        OP_RESET:     nxt_query = 1'b0;
                        OP_SEC_ENTER: nxt_secured = 1'b1;
                        OP_SEC_EXIT:  nxt_secured = 1'b0;
                        OP_BYP_ENTER: nxt_bypass = 1'b1;
                        OP_BYP_RESET: nxt_bypass = 1'b0;
                        default: ;
                    endcase
                    if (op_ff == OP_PROGRAM || op_ff == OP_BYP_PROG
                        || op_ff == OP_CHIP_ER) begin
                        nxt_cnt   = BUSY_CYC;
                        nxt_state = S_BUSY;
                    end else begin
                        nxt_done  = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_BUSY: begin
                if (cnt_ff != 8'h00) begin
                    nxt_cnt = cnt_ff - 8'h01;
                end else if (ready_busy_n) begin
                    nxt_done  = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_READ: begin
                nxt_ce_n = 1'b0;
                nxt_oe_n = 1'b0;
                nxt_cnt  = cnt_ff - 8'h01;
                if (cnt_ff == 8'h00) begin
                    nxt_rdata = flash_dq_in;
                    nxt_done  = 1'b1;
                    nxt_ce_n  = 1'b1;
                    nxt_oe_n  = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_HWRST: begin
                nxt_rst_n = 1'b0;
                nxt_cnt   = cnt_ff - 8'h01;
                if (cnt_ff == 8'h00) begin
                    nxt_rst_n   = 1'b1;
                    nxt_query   = 1'b0;
                    nxt_secured = 1'b0;
                    nxt_bypass  = 1'b0;
                    nxt_done    = 1'b1;
                    nxt_state   = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
        if (start && state_ff != S_IDLE) begin
            nxt_err = 1'b1;
        end
        nxt_byte_n = !nxt_byte;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;   op_ff <= OP_READ;   idx_ff <= 3'h0;
            cnt_ff   <= 8'h00;    addr_ff <= '0;      uaddr_ff <= '0;
            wdata_ff <= 16'h0000; dq_ff <= 16'h0000;  rdata_ff <= 16'h0000;
            dq_oe_ff <= 1'b0;     ce_n_ff <= 1'b1;    we_n_ff <= 1'b1;
            oe_n_ff  <= 1'b1;     rst_n_ff <= 1'b1;   byte_ff <= 1'b0;
            accel_ff <= 1'b0;     query_ff <= 1'b0;   secured_ff <= 1'b0;
            bypass_ff <= 1'b0;    err_ff <= 1'b0;     done_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            byte_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state; op_ff <= nxt_op;     idx_ff <= nxt_idx;
            cnt_ff   <= nxt_cnt;   addr_ff <= nxt_addr; uaddr_ff <= nxt_uaddr;
            wdata_ff <= nxt_wdata; dq_ff <= nxt_dq;     rdata_ff <= nxt_rdata;
            dq_oe_ff <= nxt_dq_oe; ce_n_ff <= nxt_ce_n; we_n_ff <= nxt_we_n;
            oe_n_ff  <= nxt_oe_n;  rst_n_ff <= nxt_rst_n; byte_ff <= nxt_byte;
            accel_ff <= nxt_accel; query_ff <= nxt_query;
            secured_ff <= nxt_secured;
            bypass_ff <= nxt_bypass; err_ff <= nxt_err; done_ff <= nxt_done;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            byte_n_ff <= nxt_byte_n;
        end
    end

    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign flash_addr        = addr_ff;
    assign flash_dq_out      = dq_ff;
    assign flash_dq_oe       = dq_oe_ff;
    assign flash_ce_n        = ce_n_ff;
    assign flash_we_n        = we_n_ff;
    assign flash_oe_n        = oe_n_ff;
    assign flash_reset_n     = rst_n_ff;
    assign width_byte_n      = byte_n_ff;
    assign protect_accel_pin = accel_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_we_pulse;
        !we_n_ff[*4] ##1 we_n_ff;
    endsequence

    a_we_with_ce: assert property (!we_n_ff |-> !ce_n_ff)
        else $error("Write strobe low without chip select.");
    a_pin_stable: assert property (!we_n_ff |=> $stable(addr_ff)
        && $stable(dq_ff) && dq_oe_ff)
        else $error("Address or data moved around the write pulse.");
    a_pulse_width: assert property ($fell(we_n_ff) |-> s_we_pulse)
        else $error("Write pulse width wrong.");
    a_query_busy: assert property (start && start_op == OP_QUERY
        && !ready_busy_n |=> err_ff && state_ff == S_IDLE)
        else $error("Query entered while device busy.");
    a_query_exit: assert property (query_ff && start
        && start_op == OP_PROGRAM |=> err_ff && state_ff == S_IDLE)
        else $error("Query mode left without reset.");
    a_sec_bypass: assert property (secured_ff && start
        && start_op == OP_BYP_ENTER |=> err_ff && !bypass_ff)
        else $error("Bypass entered while secured.");
    a_bypass_only: assert property (bypass_ff && start
        && start_op == OP_CHIP_ER |=> err_ff && state_ff == S_IDLE)
        else $error("Command other than bypass ones accepted.");
    a_hwrst_len: assert property ($fell(rst_n_ff) |-> !rst_n_ff[*8])
        else $error("Hardware reset pulse too short.");
    a_busy_wait: assert property (state_ff == S_BUSY && cnt_ff == 8'h00
        && !ready_busy_n |=> state_ff == S_BUSY)
        else $error("Busy wait ended while device busy.");
    a_query_after: assert property ($rose(query_ff)
        |-> $past(state_ff) == S_HOLD && $past(op_ff) == OP_QUERY)
        else $error("Query mode set without entry sequence.");
    a_sec_after: assert property ($rose(secured_ff)
        |-> $past(op_ff) == OP_SEC_ENTER && $past(idx_ff) == 3'h2)
        else $error("Secured mode set without entry sequence.");

endmodule : flash_cmd_sequencer

// [inc/flash_host_pkg.sv]
/*
 * Constants, types and command codes for the flash command host.
 * Assumes a 100 MHz pclk and a parallel flash with asynchronous strobes.
 */
package flash_host_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ   = 100;
    localparam int T_WP_NS   = 35;
    localparam int T_ACC_NS  = 70;
    localparam int T_RP_NS   = 500;
    localparam int T_BUSY_NS = 90;

    function automatic logic [7:0] ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction : ns_to_cyc

    localparam logic [7:0] WP_CYC   = ns_to_cyc(T_WP_NS);
    localparam logic [7:0] ACC_CYC  = ns_to_cyc(T_ACC_NS);
    localparam logic [7:0] RP_CYC   = ns_to_cyc(T_RP_NS);
    localparam logic [7:0] BUSY_CYC = ns_to_cyc(T_BUSY_NS);

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_WDATA  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_RDATA  = 8'h10;
    localparam logic [7:0] OFF_CONFIG = 8'h14;

    localparam int ST_BUSY    = 0;
    localparam int ST_ERR     = 1;
    localparam int ST_QUERY   = 2;
    localparam int ST_SECURED = 3;
    localparam int ST_BYPASS  = 4;
    localparam int ST_RB      = 5;
    localparam int ST_DONE    = 6;
    localparam int CFG_BYTE   = 0;
    localparam int CFG_ACCEL  = 1;

    // ------------------------------------------------------------------
    // Flash command codes and unlock addresses
    // ------------------------------------------------------------------
    localparam int FLASH_AW = 22;
    localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
    localparam logic [7:0]  CMD_QUERY    = 8'h90;
    localparam logic [7:0]  CMD_RESET    = 8'hF0;
    localparam logic [7:0]  CMD_PROG     = 8'hA0;
    localparam logic [7:0]  CMD_BYPASS   = 8'h20;
    localparam logic [7:0]  CMD_ER_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ER  = 8'h10;
    localparam logic [7:0]  CMD_SEC_IN   = 8'h88;
    localparam logic [7:0]  CMD_SEC_OUT  = 8'h90;
    localparam logic [7:0]  CMD_BYP_OUT  = 8'h90;
    localparam logic [7:0]  CMD_EXIT2    = 8'h00;
    localparam logic [11:0] UNL_A1_WORD  = 12'h555;
    localparam logic [11:0] UNL_A2_WORD  = 12'h2AA;
    localparam logic [11:0] UNL_A1_BYTE  = 12'hAAA;
    localparam logic [11:0] UNL_A2_BYTE  = 12'h555;

    typedef enum logic [3:0] {
        OP_READ      = 4'h0,
        OP_RESET     = 4'h1,
        OP_QUERY     = 4'h2,
        OP_SEC_ENTER = 4'h3,
        OP_SEC_EXIT  = 4'h4,
        OP_PROGRAM   = 4'h5,
        OP_BYP_ENTER = 4'h6,
        OP_BYP_PROG  = 4'h7,
        OP_BYP_RESET = 4'h8,
        OP_CHIP_ER   = 4'h9,
        OP_HW_RESET  = 4'hA
    } op_t;

    typedef struct packed {
        logic [FLASH_AW-1:0] addr;
        logic [15:0]         data;
        logic                last;
    } step_t;

endpackage : flash_host_pkg

// [test/flash_dev_model.sv]
/* Behavioural flash: command decoder, 16-word array, busy pin.
   Assumes word-mode strobes and data as the host block drives them. */
`timescale 1ns/10ps
module flash_dev_model #(
    parameter logic [15:0] QCODE = 16'h0000
) (
    input  wire logic [21:0] addr,
    input  wire logic [15:0] dq,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        rst_n,
    output logic      [15:0] dq_rd,
    output logic             rb_n
);
    logic [15:0] mem [16];
    logic [3:0]  la;
    logic        qry, byp, sec;
    int          st;
    initial begin
        rb_n = 1'b1;
        qry = 1'b0;
        st = 0;
        byp = 1'b0;
        sec = 1'b0;
        foreach (mem[i]) mem[i] = 16'hFFFF;
    end
    assign dq_rd = (!ce_n && !oe_n) ? (qry ? QCODE : mem[addr[3:0]])
                                    : ~mem[addr[3:0]];
    always @(negedge we_n or negedge ce_n)
        if (!ce_n && !we_n) la = addr[3:0];
    always @(negedge rst_n) begin
        byp = 1'b0;
        sec = 1'b0;
        rb_n = 1'b1;
        qry = 1'b0;
        st = 0;
    end
    always @(posedge we_n) if (rst_n && rb_n) begin
        if (dq[7:0] == 8'hF0) qry = 1'b0;
        case (st)
            0, 1, 4, 5: begin
                if (byp && st == 0)
                    st = dq[7:0] == 8'hA0 ? 3 : dq[7:0] == 8'h90 ? 7 : 0;
                else if (dq[7:0] == ((st % 4 != 0) ? 8'h55 : 8'hAA))
                    st = st + 1;
                else st = 0;
            end
            2: begin
                byp = byp | (!sec && dq[7:0] == 8'h20);
                sec = sec | (dq[7:0] == 8'h88);
                qry = qry | (!sec && dq[7:0] == 8'h90);
                st = dq[7:0] == 8'hA0 ? 3 : dq[7:0] == 8'h80 ? 4
                   : (sec && dq[7:0] == 8'h90) ? 7 : 0;
            end
            7: begin
                if (dq[7:0] == 8'h00) begin
                    byp = 1'b0;
                    sec = 1'b0;
                end
                st = 0;
            end
            default: begin
                if (st == 3) mem[la] = mem[la] & dq;
                else if (dq[7:0] == 8'h10) foreach (mem[i]) mem[i] = '1;
                rb_n <= 1'b0;
                rb_n <= #400 1'b1;
                st = 0;
            end
        endcase
    end
endmodule : flash_dev_model

// [test/tb_flash_cmd_sequencer.sv]
/* Self-checking bench for the flash host with a behavioural flash.
   Assumes the register map and op codes of flash_host_pkg. */
`timescale 1ns/10ps
module tb_flash_cmd_sequencer import flash_host_pkg::*;;
    localparam logic [15:0] QC = 16'h0C3C; // Arbitrary query code.
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, v, r, seed = 32'h0000_0048;
    logic [FLASH_AW-1:0] fa;
    logic [15:0]         dqo, dqi, m [16];
    logic                oe, ce, we, re, rst, bn, acc, rb;
    int                  n_errors = 0, n_tests = 0, cyc = 0;
    always #5 pclk = ~pclk;
    flash_cmd_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr(fa),
        .flash_dq_out(dqo), .flash_dq_oe(oe), .flash_dq_in(dqi),
        .flash_ce_n(ce), .flash_we_n(we), .flash_oe_n(re),
        .flash_reset_n(rst), .width_byte_n(bn), .protect_accel_pin(acc),
        .ready_busy_n(rb));
    flash_dev_model #(.QCODE(QC)) u_flash (.addr(fa), .dq(dqo), .ce_n(ce),
        .we_n(we), .oe_n(re), .rst_n(rst), .dq_rd(dqi), .rb_n(rb));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata; se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic start(input op_t o, input logic [21:0] a,
                         input logic [15:0] d);
        apb(1'b1, OFF_ADDR, {10'h000, a});
        apb(1'b1, OFF_WDATA, {16'h0000, d});
        apb(1'b1, OFF_CTRL, {28'h000_0000, o});
    endtask : start
    task automatic fin(input logic er);
        do apb(1'b0, OFF_STATUS, 32'h0000_0000); while (v[ST_BUSY] !== 1'b0);
        chk("err", {31'h0, er}, {31'h0, v[ST_ERR]});
        apb(1'b1, OFF_STATUS, 32'h0000_0042);
    endtask : fin
    task automatic op(input op_t o, input logic [21:0] a,
                      input logic [15:0] d, input logic er);
        start(o, a, d);
        fin(er);
    endtask : op
    task automatic rdf(input logic [3:0] a, input logic [15:0] e);
        op(OP_READ, {18'h0_0000, a}, 16'h0000, 1'b0);
        apb(1'b0, OFF_RDATA, 32'h0000_0000);
        chk("rdata", {16'h0000, e}, v);
    endtask : rdf
    task automatic mode(input logic [2:0] e);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("mode", {29'h0, e}, {29'h0, v[ST_BYPASS:ST_QUERY]});
    endtask : mode
    always @(posedge pclk) if (++cyc == 20000) begin
        n_errors++;
        final_report();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000;
        foreach (m[i]) m[i] = 16'hFFFF;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0020, v);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, se});
        for (int i = 0; i < 6; i++) begin
            r = xs();
            op(OP_PROGRAM, {20'h0_0000, r[1:0]}, r[31:16], 1'b0);
            m[r[1:0]] &= r[31:16];
            rdf({2'h0, r[1:0]}, m[r[1:0]]);
        end
        $display("program test done");
        op(OP_QUERY, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h1);
        rdf(4'h1, QC);
        rdf(4'h2, QC);
        op(OP_PROGRAM, 22'h00_0000, 16'h0000, 1'b1);
        op(OP_RESET, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h0);
        rdf(4'h0, m[0]);
        op(OP_SEC_ENTER, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h2);
        op(OP_BYP_ENTER, 22'h00_0000, 16'h0000, 1'b1);
        op(OP_SEC_EXIT, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h0);
        op(OP_HW_RESET, 22'h00_0000, 16'h0000, 1'b0);
        op(OP_BYP_PROG, 22'h00_0000, 16'h0000, 1'b1);
        apb(1'b1, OFF_CONFIG, 32'h0000_0003);
        chk("pins", 32'h0000_0002, {30'h0, acc, bn});
        op(OP_PROGRAM, 22'h00_0000, 16'h0000, 1'b1);
        apb(1'b1, OFF_CONFIG, 32'h0000_0000);
        chk("pins", 32'h0000_0001, {30'h0, acc, bn});
        $display("mode test done");
        start(OP_PROGRAM, 22'h00_0003, 16'h00F0);
        apb(1'b1, OFF_CTRL, {28'h000_0000, OP_RESET});
        fin(1'b1);
        rdf(4'h3, m[3] & 16'h00F0);
        op(OP_CHIP_ER, 22'h00_0000, 16'h0000, 1'b0);
        rdf(4'h3, 16'hFFFF);
        foreach (m[i]) m[i] = 16'hFFFF;
        op(OP_BYP_ENTER, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h4);
        op(OP_CHIP_ER, 22'h00_0000, 16'h0000, 1'b1);
        r = xs();
        op(OP_BYP_PROG, {20'h0_0000, r[1:0]}, r[31:16], 1'b0);
        m[r[1:0]] &= r[31:16];
        rdf({2'h0, r[1:0]}, m[r[1:0]]);
        op(OP_BYP_RESET, 22'h00_0000, 16'h0000, 1'b0);
        mode(3'h0);
        $display("busy and erase test done");
        final_report();
    end
endmodule : tb_flash_cmd_sequencer
